// File: hdl/spd_pkg.sv
// package for the sleep power-down controller: map, fields, timing
package spd_pkg;
  // register byte offsets on the register bus
  localparam logic [7:0] OFS_STATUS = 8'h00;  // core_status_flags
  localparam logic [7:0] OFS_VREG   = 8'h04;  // regulator_power_control
  localparam logic [7:0] OFS_WDOG   = 8'h08;  // watchdog_control
  localparam logic [7:0] OFS_CTRL   = 8'h0C;  // sleep control / configuration
  localparam logic [7:0] OFS_STATE  = 8'h10;  // controller state, read only
  localparam logic [7:0] OFS_WDCNT  = 8'h14;  // watchdog counter, read only

  // core_status_flags field positions
  localparam int STAT_PD_BIT = 3;   // power_down_flag_n
  localparam int STAT_TO_BIT = 4;   // timeout_flag_n
  // regulator_power_control fields and reset value
  localparam int VREG_RSV_BIT = 0;
  localparam int VREG_PM_BIT  = 1;  // regulator_sleep_power_mode
  localparam logic [7:0] VREG_RESET  = 8'h01;
  // watchdog_control fields and reset value
  localparam int WDOG_EN_BIT = 0;   // software_watchdog_enable
  localparam int WDOG_PS_LSB = 1;   // watchdog_period_select
  localparam logic [7:0] WDOG_RESET = 8'h16;
  // sleep control register fields
  localparam int CTRL_XTAL_BIT = 0; // system clock is a crystal mode
  localparam int CTRL_WSLP_BIT = 1; // watchdog enabled during power-down
  localparam int CTRL_INCP_BIT = 2; // low-power-incompatible peripheral on
  localparam logic [7:0] CTRL_RESET = 8'h02;

  // timing
  localparam int OST_PERIODS   = 1024;  // oscillator start-up, in osc periods
  localparam int CLK_MHZ       = 250;
  localparam int VREG_STAB_NS  = 2000;  // default regulator settle time
  localparam int VREG_STAB_CYC = (VREG_STAB_NS * CLK_MHZ + 999) / 1000;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    SPD_RUN, SPD_ENTER, SPD_SLEEP, SPD_OST, SPD_VREG, SPD_RESUME
  } spd_state_e;

  // wake request bundle coming from the interrupt logic
  typedef struct packed {
    logic [7:0] irq_flags;    // pending interrupt flags
    logic [7:0] irq_enables;  // individual enable bits
    logic       global_irq_enable;          // global_irq_enable
  } spd_irq_s;

  // indications back to the core
  typedef struct packed {
    logic cpu_clk_en;     // cpu clock gate enable
    logic vreg_low_power; // regulator in low-power state
    logic resume;         // one-cycle: execution continues
    logic vector_isr;     // one-cycle: vector after next instruction
    logic prefetch;       // one-cycle: fetch next address
  } spd_core_s;
endpackage

// File: hdl/spd_sleep_ctrl.sv
// sleep power-down controller with its AXI4-Lite register slave
// Summary of operation
// RQ1: sleep is entered only on the core's power-down instruction strobe.
// RQ2: watchdog counter clears on entry, keeps counting when enabled in sleep.
// RQ3: completed entry clears power-down flag and sets time-out flag.
// RQ4: cpu clock gate is off while asleep.
// RQ5: low-frequency oscillator stays enabled during sleep.
// RQ6: secondary oscillator stays enabled during sleep.
// RQ7: adc keeps its dedicated rc clock during sleep.
// RQ8: io pins hold their pre-sleep drive state while asleep.
// RQ9: non-watchdog resets act the same asleep as awake.
// RQ10: pin, brownout, power-on reset; watchdog and interrupts resume execution.
// RQ11: next program address is prefetched during the power-down instruction.
// RQ12: only individually enabled interrupts wake, regardless of global enable.
// RQ13: wake resumes at next instruction, then vectors if global enable set.
// RQ14: software places a no-operation after the power-down instruction.
// RQ15: watchdog counter is cleared on every wake-up.
// RQ16: enabled pending interrupt makes the instruction a no-operation.
// RQ17: interrupt during entry completes entry then wakes at once.
// RQ18: software reads the power-down flag to see whether sleep happened.
// RQ19: crystal modes wait 1024 oscillator periods before resuming.
// RQ20: regulator power-mode bit selects low-power regulator during sleep.
// RQ21: low-power regulator wake adds a stabilisation delay.
// RQ22: incompatible peripherals force normal regulator mode in sleep.
// RQ23: regulator bit 0 reads one, bits 7-2 read zero, mode resets zero.
// RQ24: watchdog time-out in sleep wakes, resumes and updates flags.
// RQ25: regulator stabilisation delay is a configurable cycle count.
`timescale 1ns/1ps
module spd_sleep_ctrl #(
  parameter int VREG_STAB_CYCLES = spd_pkg::VREG_STAB_CYC,
  parameter int OST_CYCLES       = spd_pkg::OST_PERIODS,
  parameter int WDOG_W           = 24
) (
  input  wire logic                clock_in,
  input  wire logic                nrst_in,
  // AXI4-Lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,
  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready,
  // core, interrupt and watchdog side
  input  wire logic                sleep_instr_in,
  input  wire logic                clear_wdog_in,
  input  wire logic                osc_tick_in,
  input  wire logic                lf_tick_in,
  input  wire spd_pkg::spd_irq_s   irq_in,
  output spd_pkg::spd_core_s       core_out,
  output logic                     wdog_reset_out,
  output logic                     lf_osc_en_out,
  output logic                     sec_osc_en_out,
  output logic                     adc_rc_en_out,
  output logic                     io_hold_out,
  output logic [WDOG_W-1:0]        wdog_count_out
);

  // reset sources other than the watchdog arrive through nrst_in unchanged
  // by sleep: every one resets the whole block, asleep or not  // RQ9 RQ10

  spd_pkg::spd_state_e state_r;
  logic [7:0]  status_r;
  logic [7:0]  vreg_r;
  logic [7:0]  wdog_ctl_r;
  logic [7:0]  ctrl_r;
  logic [WDOG_W-1:0] wdog_cnt_r;
  logic [15:0] dly_cnt_r;
  logic        was_low_power_r;

  // awaiting-bus state
  logic        aw_hold_r;
  logic        w_hold_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  logic        irq_wake;
  logic        wdog_en;
  logic        wdog_expired;
  logic        entry_ok;
  logic        wr_fire;
  logic [WDOG_W-1:0] wdog_limit;

  // write a byte lane set into an 8-bit register, lane 0 only
  function automatic logic [7:0] lane0(input logic [7:0] old, input logic [31:0] d,
                                       input logic [3:0] s);
    lane0 = s[0] ? d[7:0] : old;
  endfunction

  // enabled-and-pending test; global enable deliberately not used  // RQ12
  assign irq_wake = |(irq_in.irq_flags & irq_in.irq_enables);
  assign wdog_en  = wdog_ctl_r[spd_pkg::WDOG_EN_BIT]
                    & ((state_r != spd_pkg::SPD_SLEEP)
                       | ctrl_r[spd_pkg::CTRL_WSLP_BIT]);
  // period select picks a power-of-two limit on the low-frequency ticks
  assign wdog_limit = {{(WDOG_W-1){1'b0}}, 1'b1}
                      << wdog_ctl_r[spd_pkg::WDOG_PS_LSB +: 5];
  assign wdog_expired = wdog_en & (wdog_cnt_r >= wdog_limit - 1'b1) & lf_tick_in;
  // a pending enabled flag turns the instruction into a no-operation  // RQ16
  assign entry_ok = sleep_instr_in & !irq_wake;

  // sleep sequencer
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      state_r   <= spd_pkg::SPD_RUN;
      dly_cnt_r <= 16'h0000;
    end else begin
      case (state_r)
        spd_pkg::SPD_RUN: begin
          if (entry_ok) begin
            state_r <= spd_pkg::SPD_ENTER;  // RQ1
          end
        end
        // entry always completes, even if an interrupt lands now  // RQ17
        spd_pkg::SPD_ENTER: begin
          state_r <= spd_pkg::SPD_SLEEP;
        end
        spd_pkg::SPD_SLEEP: begin
          if (irq_wake || wdog_expired) begin  // RQ24 RQ10
            dly_cnt_r <= 16'h0000;
            if (ctrl_r[spd_pkg::CTRL_XTAL_BIT]) begin
              state_r <= spd_pkg::SPD_OST;
            end else if (was_low_power_r) begin
              state_r <= spd_pkg::SPD_VREG;
            end else begin
              state_r <= spd_pkg::SPD_RESUME;
            end
          end
        end
        // oscillator start-up: count crystal periods  // RQ19
        spd_pkg::SPD_OST: begin
          if (osc_tick_in) begin
            if (dly_cnt_r == 16'(OST_CYCLES - 1)) begin
              dly_cnt_r <= 16'h0000;
              state_r   <= was_low_power_r ? spd_pkg::SPD_VREG : spd_pkg::SPD_RESUME;
            end else begin
              dly_cnt_r <= dly_cnt_r + 16'h0001;
            end
          end
        end
        // extra regulator settle time after low-power sleep  // RQ21 RQ25
        spd_pkg::SPD_VREG: begin
          if (dly_cnt_r >= 16'(VREG_STAB_CYCLES - 1)) begin
            state_r <= spd_pkg::SPD_RESUME;
          end else begin
            dly_cnt_r <= dly_cnt_r + 16'h0001;
          end
        end
        spd_pkg::SPD_RESUME: begin
          state_r <= spd_pkg::SPD_RUN;
        end
        default: begin
          state_r <= spd_pkg::SPD_RUN;
        end
      endcase
    end
  end

  // regulator mode latched at entry; incompatible peripherals veto it  // RQ20 RQ22
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      was_low_power_r <= 1'b0;
    end else if (state_r == spd_pkg::SPD_ENTER) begin
      was_low_power_r <= vreg_r[spd_pkg::VREG_PM_BIT]
                         & !ctrl_r[spd_pkg::CTRL_INCP_BIT];
    end
  end

  // watchdog counter: cleared on entry, on wake and during start-up
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      wdog_cnt_r     <= '0;
      wdog_reset_out <= 1'b0;
    end else begin
      wdog_reset_out <= 1'b0;
      if (state_r == spd_pkg::SPD_ENTER) begin
        wdog_cnt_r <= '0;  // RQ2
      end else if (state_r == spd_pkg::SPD_OST || state_r == spd_pkg::SPD_VREG
                   || state_r == spd_pkg::SPD_RESUME) begin
        wdog_cnt_r <= '0;  // RQ15
      end else if (clear_wdog_in || !wdog_en) begin
        wdog_cnt_r <= '0;
      end else if (wdog_expired) begin
        wdog_cnt_r <= '0;
        // awake time-out resets; asleep it only wakes  // RQ24
        wdog_reset_out <= (state_r == spd_pkg::SPD_RUN);
      end else if (lf_tick_in) begin
        wdog_cnt_r <= wdog_cnt_r + 1'b1;  // RQ2
      end
    end
  end

  // core-facing outputs, all registered
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      core_out       <= '{cpu_clk_en: 1'b1, default: 1'b0};
      lf_osc_en_out  <= 1'b1;
      sec_osc_en_out <= 1'b1;
      adc_rc_en_out  <= 1'b1;
      io_hold_out    <= 1'b0;
      wdog_count_out <= '0;
    end else begin
      // clock gated from entry until the wake delays end  // RQ4
      core_out.cpu_clk_en     <= !(state_r == spd_pkg::SPD_ENTER
                                   || state_r == spd_pkg::SPD_SLEEP
                                   || state_r == spd_pkg::SPD_OST
                                   || state_r == spd_pkg::SPD_VREG) || entry_ok ? 
                                 !entry_ok && !(state_r == spd_pkg::SPD_ENTER
                                   || state_r == spd_pkg::SPD_SLEEP
                                   || state_r == spd_pkg::SPD_OST
                                   || state_r == spd_pkg::SPD_VREG) : 1'b0;
      core_out.vreg_low_power <= (state_r == spd_pkg::SPD_SLEEP) && was_low_power_r;
      core_out.prefetch       <= sleep_instr_in && state_r == spd_pkg::SPD_RUN;  // RQ11
      // resume at next instruction; vector only when global enable set  // RQ13
      core_out.resume         <= state_r == spd_pkg::SPD_RESUME;
      core_out.vector_isr     <= state_r == spd_pkg::SPD_RESUME && irq_in.global_irq_enable && irq_wake;
      lf_osc_en_out           <= 1'b1;  // RQ5
      sec_osc_en_out          <= 1'b1;  // RQ6
      adc_rc_en_out           <= 1'b1;  // RQ7
      // hold starts with the gated clock, so pins never move while the core is stopped
      io_hold_out             <= entry_ok
                                 || (state_r != spd_pkg::SPD_RUN
                                     && state_r != spd_pkg::SPD_RESUME);  // RQ8
      wdog_count_out          <= wdog_cnt_r;
    end
  end

  assign wr_fire = aw_hold_r && w_hold_r && !s_axi_bvalid;

  // status flags: hardware events win over software writes  // RQ3 RQ17 RQ24
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      status_r <= 8'h18;
    end else begin
      if (wr_fire && aw_addr_r == spd_pkg::OFS_STATUS) begin
        status_r <= lane0(status_r, w_data_r, w_strb_r) & 8'h18;
      end
      if (state_r == spd_pkg::SPD_ENTER) begin
        status_r[spd_pkg::STAT_PD_BIT] <= 1'b0;  // RQ3
        status_r[spd_pkg::STAT_TO_BIT] <= 1'b1;  // RQ3
      end else if (wdog_expired && state_r == spd_pkg::SPD_SLEEP) begin
        status_r[spd_pkg::STAT_PD_BIT] <= 1'b0;  // RQ24
        status_r[spd_pkg::STAT_TO_BIT] <= 1'b0;  // RQ24
      end
    end
  end

  // software registers
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      vreg_r     <= spd_pkg::VREG_RESET;
      wdog_ctl_r <= spd_pkg::WDOG_RESET;
      ctrl_r     <= spd_pkg::CTRL_RESET;
    end else if (wr_fire) begin
      case (aw_addr_r)
        // only the mode bit is writable; bit 0 stays one  // RQ23
        spd_pkg::OFS_VREG: vreg_r <= (lane0(vreg_r, w_data_r, w_strb_r) & 8'h02) | 8'h01;
        spd_pkg::OFS_WDOG: wdog_ctl_r <= lane0(wdog_ctl_r, w_data_r, w_strb_r) & 8'h3F;
        spd_pkg::OFS_CTRL: ctrl_r <= lane0(ctrl_r, w_data_r, w_strb_r) & 8'h07;
        default: ;
      endcase
    end
  end

  // write channel: address and data taken in either order, then response
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      aw_hold_r     <= 1'b0;
      w_hold_r      <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= spd_pkg::RESP_OKAY;
    end else begin
      s_axi_awready <= !aw_hold_r && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_hold_r && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_hold_r <= 1'b1;
        aw_addr_r <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_hold_r <= 1'b1;
        w_data_r <= s_axi_wdata;
        w_strb_r <= s_axi_wstrb;
      end
      if (wr_fire) begin
        aw_hold_r    <= 1'b0;
        w_hold_r     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (aw_addr_r == spd_pkg::OFS_STATUS || aw_addr_r == spd_pkg::OFS_VREG
                         || aw_addr_r == spd_pkg::OFS_WDOG || aw_addr_r == spd_pkg::OFS_CTRL)
                        ? spd_pkg::RESP_OKAY : spd_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // read channel
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= spd_pkg::RESP_OKAY;
    end else begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (s_axi_arvalid && s_axi_arready) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= spd_pkg::RESP_OKAY;
        case (s_axi_araddr)
          spd_pkg::OFS_STATUS: s_axi_rdata <= {24'h000000, status_r};  // RQ18
          spd_pkg::OFS_VREG:   s_axi_rdata <= {24'h000000, vreg_r};    // RQ23
          spd_pkg::OFS_WDOG:   s_axi_rdata <= {24'h000000, wdog_ctl_r};
          spd_pkg::OFS_CTRL:   s_axi_rdata <= {24'h000000, ctrl_r};
          spd_pkg::OFS_STATE:  s_axi_rdata <= {28'h0000000, was_low_power_r,
                                               state_r};
          spd_pkg::OFS_WDCNT:  s_axi_rdata <= 32'(wdog_cnt_r);
          default: begin
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= spd_pkg::RESP_SLVERR;
          end
        endcase
      end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

endmodule

// File: tb/spd_sleep_ctrl_monitor.sv
// checker on the sleep controller ports
`timescale 1ns/1ps
module spd_sleep_monitor #(
  parameter int WDOG_W = 24
) (
  input wire logic               clock_in,
  input wire logic               nrst_in,
  input wire logic               sleep_instr_in,
  input wire spd_pkg::spd_irq_s  irq_in,
  input wire spd_pkg::spd_core_s core_out,
  input wire logic               wdog_reset_out,
  input wire logic               lf_osc_en_out,
  input wire logic               sec_osc_en_out,
  input wire logic               adc_rc_en_out,
  input wire logic               io_hold_out,
  input wire logic [WDOG_W-1:0]  wdog_count_out
);
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!nrst_in);
  logic pend;
  // enabled pending flag, whatever the global enable says
  assign pend = |(irq_in.irq_flags & irq_in.irq_enables);
  // two steps of a sleep entry: accepted instruction, then gated clock with prefetch
  sequence s_take; sleep_instr_in && core_out.cpu_clk_en && !pend; endsequence
  sequence s_gate; core_out.prefetch && !core_out.cpu_clk_en && io_hold_out; endsequence
  property p_enter; s_take |=> s_gate; endproperty
  property p_noop; sleep_instr_in && core_out.cpu_clk_en && pend |=>
    core_out.cpu_clk_en && core_out.prefetch; endproperty
  property p_cause; $fell(core_out.cpu_clk_en) |-> $past(sleep_instr_in); endproperty
  property p_hold; $fell(core_out.cpu_clk_en) |-> io_hold_out; endproperty
  property p_osc; lf_osc_en_out && sec_osc_en_out && adc_rc_en_out; endproperty
  property p_wake; $rose(core_out.cpu_clk_en) |-> core_out.resume; endproperty
  property p_vec; core_out.resume && pend |-> core_out.vector_isr == irq_in.global_irq_enable; endproperty
  property p_wdin; $fell(core_out.cpu_clk_en) |-> ##[1:3] (wdog_count_out == '0); endproperty
  property p_wdout; $rose(core_out.cpu_clk_en) |-> ##[0:2] (wdog_count_out == '0); endproperty
  property p_wdrst; wdog_reset_out |-> $past(core_out.cpu_clk_en); endproperty
  property p_lp; core_out.vreg_low_power |-> io_hold_out && !core_out.cpu_clk_en; endproperty
  a_enter: assert property (p_enter) else $error("sleep entry not gated");
  a_noop: assert property (p_noop) else $error("pending flag did not cancel sleep");
  a_cause: assert property (p_cause) else $error("clock stopped without instruction");
  a_hold: assert property (p_hold) else $error("pins not held on entry");
  a_osc: assert property (p_osc) else $error("sleep-time clock disabled");
  a_wake: assert property (p_wake) else $error("clock back without resume");
  a_vec: assert property (p_vec) else $error("vector does not follow global enable");
  a_wdin: assert property (p_wdin) else $error("watchdog not cleared on entry");
  a_wdout: assert property (p_wdout) else $error("watchdog not cleared on wake");
  a_wdrst: assert property (p_wdrst) else $error("watchdog reset while asleep");
  a_lp: assert property (p_lp) else $error("low-power regulator while awake");
endmodule
bind spd_sleep_ctrl spd_sleep_monitor #(.WDOG_W(WDOG_W)) u_mon (.clock_in, .nrst_in,
  .sleep_instr_in, .irq_in, .core_out, .wdog_reset_out, .lf_osc_en_out, .sec_osc_en_out,
  .adc_rc_en_out, .io_hold_out, .wdog_count_out);

// File: tb/spd_core_model.sv
// core-side model: oscillator ticks and resume count
`timescale 1ns/1ps
module spd_core_model #(
  parameter int OSC_DIV = 2,
  parameter int LF_DIV  = 16
) (
  input  wire logic               clock_in,
  input  wire logic               nrst_in,
  input  wire spd_pkg::spd_core_s core_in,
  output logic                    osc_tick_out,
  output logic                    lf_tick_out,
  output int                      resume_cnt_out
);
  int osc_c;
  int lf_c;
  // both oscillators run free, asleep or awake
  always_ff @(posedge clock_in) begin
    if (!nrst_in) begin
      osc_c <= 0;
      lf_c  <= 0;
    end else begin
      osc_c <= (osc_c + 1) % OSC_DIV;
      lf_c  <= (lf_c + 1) % LF_DIV;
    end
  end
  assign osc_tick_out = (osc_c == OSC_DIV - 1);
  assign lf_tick_out  = (lf_c == LF_DIV - 1);
  // word after each sleep is a no_operation, so a resume runs nothing extra
  always_ff @(posedge clock_in) begin
    if (!nrst_in) resume_cnt_out <= 0;
    else if (core_in.resume) resume_cnt_out <= resume_cnt_out + 1;
  end
endmodule

// File: tb/spd_sleep_ctrl_tb.sv
// self-checking bench for the sleep power-down controller
`timescale 1ns/1ps
module spd_sleep_ctrl_tb;
  localparam int OSCILLATOR_STARTUP_TIMER = 8;
  localparam int VST = 4;
  logic               clock_in = 0;
  logic               nrst_in = 0;
  logic [7:0]         s_axi_awaddr = 0;
  logic [7:0]         s_axi_araddr = 0;
  logic [31:0]        s_axi_wdata = 0;
  logic [3:0]         s_axi_wstrb = 4'h1;
  logic               s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
  logic               s_axi_arvalid = 0, s_axi_rready = 0;
  logic               s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]         s_axi_bresp, s_axi_rresp, rsp;
  logic [31:0]        s_axi_rdata, rdv;
  logic               sleep_instr_in = 0, clear_wdog_in = 0, osc_tick_in, lf_tick_in;
  spd_pkg::spd_irq_s  irq_in = '0;
  spd_pkg::spd_core_s core_out;
  logic [7:0]         seed = 8'h5D;
  int                 num_errors = 0, total_checks = 0, rsm, wd_pulses = 0, cyc, tk;

  logic               wd_rst;
  always #2 clock_in = ~clock_in;
  spd_sleep_ctrl #(.VREG_STAB_CYCLES(VST), .OST_CYCLES(OSCILLATOR_STARTUP_TIMER), .WDOG_W(24)) dut (.clock_in,
    .nrst_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .sleep_instr_in, .clear_wdog_in, .osc_tick_in, .lf_tick_in, .irq_in, .core_out,
    .wdog_reset_out(wd_rst), .lf_osc_en_out(), .sec_osc_en_out(), .adc_rc_en_out(),
    .io_hold_out(), .wdog_count_out());
  spd_core_model u_model (.clock_in, .nrst_in, .core_in(core_out), .osc_tick_out(osc_tick_in),
    .lf_tick_out(lf_tick_in), .resume_cnt_out(rsm));
  // count reset requests from the watchdog
  always @(posedge clock_in) if (wd_rst === 1'b1) wd_pulses++;

  function automatic logic [7:0] lfsr(input logic [7:0] s);
    lfsr = {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction
  // expected status word from the two active-low flags
  function automatic logic [31:0] st(input logic pd_n, input logic to_n);
    st = 32'(pd_n) << spd_pkg::STAT_PD_BIT | 32'(to_n) << spd_pkg::STAT_TO_BIT;
  endfunction
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    for (int n = 0; n < 50; n++) begin
      @(posedge clock_in);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    rdv = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge clock_in);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e,
                      input string nm);
    rd(a);
    chk(nm, e, rdv & m);
  endtask
  task automatic pulse_sleep();
    sleep_instr_in <= 1'b1;
    @(posedge clock_in);
    sleep_instr_in <= 1'b0;
  endtask
  // waits for the resume pulse, counting crystal ticks meanwhile
  task automatic wake_wait();
    tk = 0;
    for (cyc = 0; cyc < 3000; cyc++) begin
      @(posedge clock_in);
      if (osc_tick_in) tk++;
      if (core_out.resume === 1'b1) break;
    end
    chk("woke", 1, cyc < 3000);
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // bounded by a generous multiple of the expected run
  initial begin
    repeat (40000) @(posedge clock_in);
    num_errors++;
    test_done();
  end

  initial begin
    repeat (16) @(posedge clock_in);
    nrst_in <= 1'b1;
    @(posedge clock_in);
    rchk(spd_pkg::OFS_STATUS, st(1, 1), st(1, 1), "status rst");
    rchk(spd_pkg::OFS_VREG, 'hFF, spd_pkg::VREG_RESET, "vreg rst");
    rchk(spd_pkg::OFS_WDOG, 'hFF, spd_pkg::WDOG_RESET, "wdog rst");
    rchk(spd_pkg::OFS_CTRL, 'hFF, spd_pkg::CTRL_RESET, "ctrl rst");
    rd(8'h20);
    chk("unmapped rd", spd_pkg::RESP_SLVERR, rsp);
    wr(8'h20, 'hFF);
    chk("unmapped wr", spd_pkg::RESP_SLVERR, rsp);
    wr(spd_pkg::OFS_VREG, 'hFF);
    rchk(spd_pkg::OFS_VREG, 'hFFFFFFFF, 'h03, "vreg set");
    wr(spd_pkg::OFS_VREG, 'h01);
    rchk(spd_pkg::OFS_VREG, 'hFFFFFFFF, 'h01, "vreg clr");
    $display("test registers done");
    // enabled flag already pending: the instruction does nothing
    irq_in <= {8'h01, 8'h01, 1'b0};
    pulse_sleep();
    repeat (4) @(posedge clock_in);
    chk("noop clk", 1, core_out.cpu_clk_en);
    rchk(spd_pkg::OFS_STATUS, st(1, 1), st(1, 1), "noop flags");
    irq_in <= {8'h00, 8'h01, 1'b1};
    pulse_sleep();
    irq_in.irq_flags <= 8'h01;
    wake_wait();
    chk("entry wake", 1, cyc < 20);
    irq_in <= '0;
    rchk(spd_pkg::OFS_STATUS, st(1, 1), st(0, 1), "entry flags");
    $display("test pending flag done");
    // watchdog running in sleep, short period: wakes, no reset
    wr(spd_pkg::OFS_CTRL, 'h02);
    wr(spd_pkg::OFS_WDOG, 'h05);
    pulse_sleep();
    wake_wait();
    wr(spd_pkg::OFS_WDOG, spd_pkg::WDOG_RESET);
    rchk(spd_pkg::OFS_STATUS, st(1, 1), st(0, 0), "wd flags");
    chk("wd no reset", 0, wd_pulses);
    wr(spd_pkg::OFS_WDOG, 'h05);
    repeat (5) begin
      repeat (20) @(posedge clock_in);
      clear_wdog_in <= 1'b1;
      @(posedge clock_in);
      clear_wdog_in <= 1'b0;
    end
    chk("wd cleared", 0, wd_pulses);
    repeat (80) @(posedge clock_in);
    chk("wd awake", 1, wd_pulses > 0);
    wr(spd_pkg::OFS_WDOG, spd_pkg::WDOG_RESET);
    $display("test watchdog done");
    // every crystal, regulator and global-enable mix, random source
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      wr(spd_pkg::OFS_CTRL, {seed[3], 2'b00} | i[0]);
      wr(spd_pkg::OFS_VREG, {i[1], 1'b1});
      irq_in <= {8'h00, ~(8'h01 << seed[2:0]), i[2]};
      pulse_sleep();
      repeat (4) @(posedge clock_in);
      chk("asleep", 0, core_out.cpu_clk_en);
      chk("lowpwr", i[1] & ~seed[3], core_out.vreg_low_power);
      rchk(spd_pkg::OFS_STATUS, st(1, 1), st(0, 1), "sleep flags");
      irq_in.irq_flags <= 8'h01 << seed[2:0];
      repeat (20) @(posedge clock_in);
      chk("masked", 0, core_out.cpu_clk_en);
      irq_in.irq_enables <= 8'hFF;
      wake_wait();
      chk("vector", i[2], core_out.vector_isr);
      chk("osc wait", 1, i[0] ? tk >= OSCILLATOR_STARTUP_TIMER : cyc < VST + 6);
      chk("stab wait", 1, cyc >= ((i[1] & ~seed[3]) ? VST : 0));
      irq_in <= '0;
      @(posedge clock_in);
    end
    chk("resumes", 10, rsm);
    $display("test sleep modes done");
    test_done();
  end
endmodule
